/* pkg/vco_cal_pkg.sv */
// Behaviour
// - Window selector codes 0000..0110 pick 1.5, 5.8, 15.1, 3.4, 7.7, 17.0 ns.
// - Codes 1000..1110 pick 5.4, 9.7, 19.0, 15.0, 19.3, 28.6 ns.
// - Power-up calibration starts only after configuration load and reference detection.
// - Without a reference the sequencer waits, then calibrates once it appears.
// - With trigger select one, a rising kick bit starts calibration.
// - Kick calibration turns outputs off but keeps every block powered.
// - With trigger select zero, sleep_n falling powers the device down.
// - With trigger select zero, sleep_n rising calibrates the VCO.
// - With trigger select zero, while sleep_n is low, outputs are off and blocks powered down; code needs a sleep_n fall in calibration or monitoring.
// - Power-down pin high-low-high with trigger select zero starts calibration.
// - That pin-started calibration first reloads configuration from nonvolatile memory.
// - After reference start, wait 16384 input-divider clock periods.
// - Calibration lasts 550 phase-detector clock periods.
// - In analog lock mode the lock pin is analog, not digital.
// - Digital lock reports locked while phase difference stays inside the window.
// - One compared cycle outside the window or a slip clears lock.
`default_nettype none
package vco_cal_pkg;

	// Sequencer states, one-hot
	typedef enum logic [7:0] {
		ST_WAIT_CFG = 8'h01,
		ST_WAIT_REF = 8'h02,
		ST_DELAY    = 8'h04,
		ST_CAL      = 8'h08,
		ST_MONITOR  = 8'h10,
		ST_SLEEP    = 8'h20,
		ST_PDOWN    = 8'h40,
		ST_RELOAD   = 8'h80
	} seq_state_e;

	// Timing in reference ticks
	localparam int          STAB_DELAY_TICKS = 16384;
	localparam int          CAL_TICKS        = 550;
	localparam int          CNT_W            = 15;
	localparam logic [14:0] CNT_ZERO         = 15'h0000;
	localparam logic [14:0] CAL_LAST         = 15'(CAL_TICKS - 1);

	// Lock window widths in picoseconds, indexed by selector code; zero marks reserved
	localparam int WIN_W = 16;
	localparam logic [15:0] WIN_PS [16] = '{
		16'h05dc, 16'h16a8, 16'h3afc, 16'h0000,
		16'h0d48, 16'h1e14, 16'h4268, 16'h0000,
		16'h1518, 16'h25e4, 16'h4a38, 16'h0000,
		16'h3a98, 16'h4b64, 16'h6fb8, 16'h0000
	};
	localparam logic [1:0] WIN_RSVD_LOW = 2'h3;

endpackage
`default_nettype wire

/* src/lock_window_check.sv */
`timescale 1ns/100ps
`default_nettype none
module lock_window_check
	import vco_cal_pkg::*;
(
	// Selector and measurement
	input  wire logic [3:0]       lock_window_sel,
	input  wire logic [WIN_W-1:0] phase_diff_ps,
	// Result
	output logic                  in_window
);

	logic [WIN_W-1:0] win_ps;

	// Table lookup; reserved codes never report in-window so a bad write cannot fake lock
	always_comb
	begin
		win_ps    = WIN_PS[lock_window_sel];
		in_window = (lock_window_sel[1:0] != WIN_RSVD_LOW)
		            && (phase_diff_ps <= win_ps);
	end

endmodule
`default_nettype wire

/* src/vco_cal_lock_ctrl.sv */
`timescale 1ns/100ps
`default_nettype none
module vco_cal_lock_ctrl
	import vco_cal_pkg::*;
#(
	parameter int DELAY_TICKS = STAB_DELAY_TICKS
)
(
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             sys_rst,
	// Pins from outside the clock domain
	input  wire logic             ref_clk_detect,
	input  wire logic             power_down_pin,
	// Configuration bits and load status
	input  wire logic             cfg_loaded,
	input  wire logic             cal_trigger_select,
	input  wire logic             cal_kick,
	input  wire logic             sleep_n,
	input  wire logic [3:0]       lock_window_sel,
	input  wire logic             analog_lock_mode,
	// Reference timing ticks
	input  wire logic             id_tick,
	input  wire logic             pfd_tick,
	// Phase comparison results
	input  wire logic             phase_valid,
	input  wire logic [WIN_W-1:0] phase_diff_ps,
	input  wire logic             cycle_slip,
	// Status and control outputs
	output logic                  cal_busy_q,
	output logic                  outputs_en_q,
	output logic                  blocks_on_q,
	output logic                  nvm_reload_q,
	output logic                  pll_lock_q,
	output logic                  lock_analog_q
);

	localparam logic [CNT_W-1:0] DELAY_LAST = CNT_W'(DELAY_TICKS - 1);

	seq_state_e       state_q, state_d;
	logic [CNT_W-1:0] cnt_q, cnt_d;
	logic             ref_m_q, ref_s_q, pd_m_q, pd_s_q, pd_prev_q;
	logic             kick_prev_q, sleep_prev_q;
	logic             cal_busy_d, outputs_en_d, blocks_on_d, nvm_reload_d, pll_lock_d, lock_analog_d;
	logic             kick_rise, sleep_fall, sleep_rise, pd_fall, pd_rise, restart, in_win;

	lock_window_check u_win (
		.lock_window_sel (lock_window_sel),
		.phase_diff_ps   (phase_diff_ps),
		.in_window       (in_win)
	);

	// Pin synchronisers; first stages feed only the second stages
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			ref_m_q   <= 1'b0;
			ref_s_q   <= 1'b0;
			pd_m_q    <= 1'b1;
			pd_s_q    <= 1'b1;
			pd_prev_q <= 1'b1;
		end
		else
		begin
			ref_m_q   <= ref_clk_detect;
			ref_s_q   <= ref_m_q;
			pd_m_q    <= power_down_pin;
			pd_s_q    <= pd_m_q;
			pd_prev_q <= pd_s_q;
		end
	end

	// Edge detection on configuration bits and the synchronised pin
	always_comb
	begin
		kick_rise  = cal_kick && !kick_prev_q && cal_trigger_select;
		sleep_fall = !sleep_n && sleep_prev_q && !cal_trigger_select;
		sleep_rise = sleep_n && !sleep_prev_q && !cal_trigger_select;
		pd_fall    = !pd_s_q && pd_prev_q;
		pd_rise    = pd_s_q && !pd_prev_q;
		restart    = kick_rise;
	end

	// Sequencer next state; triggers are honoured only once power-up calibration has started
	always_comb
	begin
		state_d      = state_q;
		cnt_d        = cnt_q;
		nvm_reload_d = 1'b0;
		case (state_q)
			ST_WAIT_CFG:
			begin
				if (cfg_loaded)
					state_d = ST_WAIT_REF;
			end
			ST_WAIT_REF:
			begin
				cnt_d = CNT_ZERO;
				if (ref_s_q)
					state_d = ST_DELAY;
			end
			ST_DELAY:
			begin
				if (id_tick)
				begin
					if (cnt_q == DELAY_LAST)
					begin
						state_d = ST_CAL;
						cnt_d   = CNT_ZERO;
					end
					else
						cnt_d = cnt_q + 1'b1;
				end
			end
			ST_CAL, ST_MONITOR:
			begin
				if (pd_fall)
					state_d = ST_PDOWN;
				else if (sleep_fall)
					state_d = ST_SLEEP;
				else if (restart)
				begin
					state_d = ST_CAL;
					cnt_d   = CNT_ZERO;
				end
				else if (state_q == ST_CAL && pfd_tick)
				begin
					if (cnt_q == CAL_LAST)
						state_d = ST_MONITOR;
					else
						cnt_d = cnt_q + 1'b1;
				end
			end
			ST_SLEEP:
			begin
				if (pd_fall)
					state_d = ST_PDOWN;
				else if (sleep_rise)
				begin
					state_d = ST_CAL;
					cnt_d   = CNT_ZERO;
				end
			end
			ST_PDOWN:
			begin
				if (pd_rise && !cal_trigger_select)
				begin
					state_d      = ST_RELOAD;
					nvm_reload_d = 1'b1;
				end
				else if (pd_rise)
					state_d = ST_MONITOR;
			end
			ST_RELOAD:
			begin
				// Calibration waits for the reloaded configuration
				if (cfg_loaded && !nvm_reload_q)
				begin
					state_d = ST_CAL;
					cnt_d   = CNT_ZERO;
				end
			end
			default:
			begin
				state_d = ST_WAIT_CFG;
				cnt_d   = CNT_ZERO;
			end
		endcase
	end

	// Output decode from the next state, so the busy, enable and power flops track the state flop
	always_comb
	begin
		cal_busy_d    = (state_d == ST_CAL);
		outputs_en_d  = (state_d == ST_MONITOR);
		blocks_on_d   = (state_d != ST_SLEEP) && (state_d != ST_PDOWN);
		lock_analog_d = analog_lock_mode;
		pll_lock_d    = pll_lock_q;
		if (state_d != ST_MONITOR || state_q != ST_MONITOR || analog_lock_mode)
			pll_lock_d = 1'b0;
		else if (cycle_slip || (phase_valid && !in_win))
			pll_lock_d = 1'b0;
		else if (phase_valid)
			pll_lock_d = 1'b1;
	end

	// State and output registers
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			state_q       <= ST_WAIT_CFG;
			cnt_q         <= CNT_ZERO;
			kick_prev_q   <= 1'b0;
			sleep_prev_q  <= 1'b1;
			cal_busy_q    <= 1'b0;
			outputs_en_q  <= 1'b0;
			blocks_on_q   <= 1'b1;
			nvm_reload_q  <= 1'b0;
			pll_lock_q    <= 1'b0;
			lock_analog_q <= 1'b0;
		end
		else
		begin
			state_q       <= state_d;
			cnt_q         <= cnt_d;
			kick_prev_q   <= cal_kick;
			sleep_prev_q  <= sleep_n;
			cal_busy_q    <= cal_busy_d;
			outputs_en_q  <= outputs_en_d;
			blocks_on_q   <= blocks_on_d;
			nvm_reload_q  <= nvm_reload_d;
			pll_lock_q    <= pll_lock_d;
			lock_analog_q <= lock_analog_d;
		end
	end

	// Checks on sequencing and lock behaviour
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	a_cfg_gates_start: assert property (state_q == ST_WAIT_CFG && !cfg_loaded |=> state_q == ST_WAIT_CFG)
		else $error("left config wait before load");
	a_ref_gates_start: assert property (state_q == ST_WAIT_REF && !ref_s_q |=> state_q == ST_WAIT_REF)
		else $error("left reference wait without reference");
	a_delay_holds: assert property (state_q == ST_DELAY && !(id_tick && cnt_q == DELAY_LAST) |=> state_q == ST_DELAY)
		else $error("stabilisation delay cut short");
	a_cal_length: assert property (state_q == ST_CAL && pfd_tick && cnt_q == CAL_LAST && !pd_fall && !sleep_fall && !restart
		|=> state_q == ST_MONITOR && outputs_en_q && !cal_busy_q)
		else $error("calibration did not end after its tick count");
	a_kick_cal: assert property (state_q == ST_MONITOR && kick_rise && !pd_fall |=> cal_busy_q && cnt_q == CNT_ZERO)
		else $error("kick edge did not start calibration");
	a_kick_power: assert property (cal_busy_q |-> !outputs_en_q && blocks_on_q)
		else $error("outputs on or blocks off during calibration");
	a_sleep_down: assert property (state_q == ST_MONITOR && sleep_fall && !pd_fall |=> !blocks_on_q && !outputs_en_q)
		else $error("sleep did not power down");
	a_sleep_wake: assert property (state_q == ST_SLEEP && sleep_rise && !pd_fall |=> cal_busy_q)
		else $error("wake did not calibrate");
	a_pin_reload: assert property (state_q == ST_PDOWN && pd_rise && !cal_trigger_select
		|=> nvm_reload_q ##1 !nvm_reload_q && !cal_busy_q)
		else $error("pin sequence did not reload first");
	a_lock_drop: assert property (state_q == ST_MONITOR && (cycle_slip || (phase_valid && !in_win)) |=> !pll_lock_q)
		else $error("lock held after bad cycle");
	a_lock_set: assert property (state_q == ST_MONITOR && state_d == ST_MONITOR && phase_valid && in_win
		&& !cycle_slip && !analog_lock_mode |=> pll_lock_q)
		else $error("lock not reported inside window");
	a_analog_pin: assert property (analog_lock_mode |=> !pll_lock_q && lock_analog_q)
		else $error("digital lock driven in analog mode");

	c_power_up: cover property (state_q == ST_DELAY ##1 state_q == ST_CAL);
	c_kick: cover property (kick_rise && state_q == ST_MONITOR);
	c_pin_reload: cover property (nvm_reload_q);
	c_locked: cover property (pll_lock_q);

endmodule
`default_nettype wire

/* verif/ref_source_model.sv */
`timescale 1ns/100ps
`default_nettype none
module ref_source_model
(
	// Clock and control
	input  wire logic clk,
	input  wire logic sys_rst,
	input  wire logic ref_on,
	input  wire logic nvm_reload_q,
	// Toward the block
	output logic      ref_clk_detect,
	output logic      id_tick,
	output logic      pfd_tick,
	output logic      cfg_loaded
);
	logic [2:0] load_q;
	logic       ph_q;

	// A dead source gives no periods, so both tick streams stop with it
	assign ref_clk_detect = ref_on;
	assign id_tick        = ref_on & ph_q;
	assign pfd_tick       = ref_on & ph_q;
	assign cfg_loaded     = (load_q == 3'h7);

	// Memory load takes seven cycles, long enough for the block to have to wait
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			ph_q   <= 1'b0;
			load_q <= 3'h0;
		end
		else
		begin
			ph_q   <= ~ph_q;
			load_q <= nvm_reload_q ? 3'h0 : load_q + {2'h0, load_q != 3'h7};
		end
	end
endmodule
`default_nettype wire

/* verif/vco_cal_lock_ctrl_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module vco_cal_lock_ctrl_tb;
	// Stimulus
	logic        clk = 1'b0;
	logic        sys_rst = 1'b1;
	logic        ref_on = 1'b0;
	logic        power_down_pin = 1'b1;
	logic        cal_trigger_select = 1'b1;
	logic        cal_kick = 1'b0;
	logic        sleep_n = 1'b1;
	logic [3:0]  lock_window_sel = 4'h0;
	logic        analog_lock_mode = 1'b0;
	logic        phase_valid = 1'b0;
	logic [15:0] phase_diff_ps = 16'h0000;
	logic        cycle_slip = 1'b0;
	// Observed
	logic        ref_clk_detect, id_tick, pfd_tick, cfg_loaded, cal_busy_q, outputs_en_q;
	logic        blocks_on_q, nvm_reload_q, pll_lock_q, lock_analog_q;
	int          failures = 0;
	int          num_checks = 0;
	// Window widths in ps of the twelve legal codes, in code order
	localparam logic [15:0] WIN [12] = '{16'h05dc, 16'h16a8, 16'h3afc, 16'h0d48, 16'h1e14, 16'h4268,
		16'h1518, 16'h25e4, 16'h4a38, 16'h3a98, 16'h4b64, 16'h6fb8};

	vco_cal_lock_ctrl #(.DELAY_TICKS(8)) u_vco_cal_lock_ctrl (.clk(clk), .sys_rst(sys_rst),
		.ref_clk_detect(ref_clk_detect), .power_down_pin(power_down_pin), .cfg_loaded(cfg_loaded),
		.cal_trigger_select(cal_trigger_select), .cal_kick(cal_kick), .sleep_n(sleep_n),
		.lock_window_sel(lock_window_sel), .analog_lock_mode(analog_lock_mode), .id_tick(id_tick),
		.pfd_tick(pfd_tick), .phase_valid(phase_valid), .phase_diff_ps(phase_diff_ps),
		.cycle_slip(cycle_slip), .cal_busy_q(cal_busy_q), .outputs_en_q(outputs_en_q),
		.blocks_on_q(blocks_on_q), .nvm_reload_q(nvm_reload_q), .pll_lock_q(pll_lock_q),
		.lock_analog_q(lock_analog_q));
	ref_source_model u_ref_source_model (.clk(clk), .sys_rst(sys_rst), .ref_on(ref_on),
		.nvm_reload_q(nvm_reload_q), .ref_clk_detect(ref_clk_detect), .id_tick(id_tick),
		.pfd_tick(pfd_tick), .cfg_loaded(cfg_loaded));

	// 100 MHz clock
	always #5 clk = ~clk;

	task automatic report_and_stop();
		$display("checks=%0d failures=%0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			failures++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Inputs always move 1 ns after the edge so the block samples them cleanly
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	// Wait for a calibration to start, then time it in clocks; ticks come every second clock
	task automatic cal_run(input int lim);
		int n;
		for (n = 0; n < lim && cal_busy_q !== 1'b1; n++) cyc(1);
		chk(cal_busy_q, 1'b1);
		for (n = 0; n < 2000 && cal_busy_q === 1'b1; n++) cyc(1);
		chk(16'(n >= 1097 && n <= 1101), 16'h0001);
		chk(outputs_en_q, 1'b1);
	endtask

	// One phase result, then one clock for the lock flag to follow
	task automatic phase(input logic [15:0] d, input logic slip);
		phase_valid = ~slip;
		phase_diff_ps = d;
		cycle_slip = slip;
		cyc(1);
		phase_valid = 1'b0;
		cycle_slip = 1'b0;
		cyc(1);
	endtask

	task automatic t_powerup();
		cyc(40);
		chk(cal_busy_q, 1'b0);
		ref_on = 1'b1;
		cyc(14);
		chk(cal_busy_q, 1'b0);
		cal_run(100);
	endtask

	task automatic t_lock();
		for (int i = 0; i < 12; i++)
		begin
			lock_window_sel = 4'(i + i / 3);
			phase(WIN[i], 1'b0);
			chk(pll_lock_q, 1'b1);
			phase(WIN[i] + 16'h0001, 1'b0);
			chk(pll_lock_q, 1'b0);
		end
		phase(16'h0000, 1'b0);
		phase(16'h0000, 1'b1);
		chk(pll_lock_q, 1'b0);
		analog_lock_mode = 1'b1;
		phase(16'h0000, 1'b0);
		chk(lock_analog_q, 1'b1);
		chk(pll_lock_q, 1'b0);
		analog_lock_mode = 1'b0;
	endtask

	task automatic t_kick();
		cal_trigger_select = 1'b0;
		cal_kick = 1'b1;
		cyc(4);
		chk(cal_busy_q, 1'b0);
		cal_kick = 1'b0;
		cal_trigger_select = 1'b1;
		cyc(1);
		cal_kick = 1'b1;
		cyc(2);
		chk(outputs_en_q, 1'b0);
		chk(blocks_on_q, 1'b1);
		// Let the count run well in, then lose the reference so the calibration stalls
		cyc(200);
		ref_on = 1'b0;
		cyc(20);
		chk(cal_busy_q, 1'b1);
		// Reference back: the controller must kick again, and the count restarts from zero
		ref_on = 1'b1;
		cal_kick = 1'b0;
		cyc(1);
		cal_kick = 1'b1;
		cal_run(5);
		cal_kick = 1'b0;
	endtask

	task automatic t_sleep();
		cal_trigger_select = 1'b0;
		sleep_n = 1'b0;
		cyc(3);
		chk(blocks_on_q, 1'b0);
		cyc(5);
		chk(outputs_en_q, 1'b0);
		chk(cal_busy_q, 1'b0);
		sleep_n = 1'b1;
		cal_run(5);
	endtask

	task automatic t_pin();
		int n;
		power_down_pin = 1'b0;
		cyc(5);
		chk(blocks_on_q, 1'b0);
		power_down_pin = 1'b1;
		n = 0;
		for (int i = 0; i < 8; i++)
		begin
			cyc(1);
			n += int'(nvm_reload_q === 1'b1);
		end
		chk(16'(n), 16'h0001);
		cal_run(40);
		// Same pin sequence with the kick path selected: back to monitor, no calibration
		cal_trigger_select = 1'b1;
		power_down_pin = 1'b0;
		cyc(5);
		chk(blocks_on_q, 1'b0);
		power_down_pin = 1'b1;
		cyc(5);
		chk(cal_busy_q, 1'b0);
		chk(outputs_en_q, 1'b1);
	endtask

	// Main sequence
	initial
	begin
		cyc(20);
		sys_rst = 1'b0;
		t_powerup();
		t_lock();
		t_kick();
		t_sleep();
		t_pin();
		report_and_stop();
	end

	// The whole run needs about 4800 clocks; give it ample slack
	initial
	begin
		#200000;
		failures++;
		report_and_stop();
	end
endmodule
`default_nettype wire
